// [core/loader_consts.svh]
`ifndef LOADER_CONSTS_SVH
`define LOADER_CONSTS_SVH

// serial eeprom read command and start address
`define LDR_CMD_READ 8'h03
`define LDR_IMAGE_START 16'h0000

// header byte zero field layout
`define LDR_SPEED_BIT 3
`define LDR_XO_MSB 2
`define LDR_XO_LSB 0
`define LDR_XO_MAX_CODE 3'h4

// rates in kHz
`define LDR_XTAL_STEP_KHZ 4000
`define LDR_SPI_SLOW_KHZ 500
`define LDR_SPI_FAST_KHZ 1000

// slowest case: 20 MHz crystal, 0.5 MHz eeprom
`define LDR_SAFE_HALF 8'h14

// floor on the half period: synchronised miso lags four cycles,
// a half period of two would sample the previous bit
`define LDR_MIN_HALF 8'h03

// header byte positions and program ram size
`define LDR_HDR_OFFSET_IDX 16'h0001
`define LDR_HDR_BLOCKS_IDX 16'h0002
`define LDR_MIN_PROG_OFFSET 8'h03
`define LDR_RAM_LAST 12'hfff
`define LDR_BLOCK_LAST 8'hff

`endif

// [core/loader_pkg.sv]
package loader_pkg;

   // gray codes along the usual load path
   typedef enum logic [3:0] {
      st_idle     = 4'h0,
      st_cmd      = 4'h1,
      st_addr_hi  = 4'h3,
      st_addr_lo  = 4'h2,
      st_hdr_rate = 4'h6,
      st_hdr_offs = 4'h7,
      st_hdr_len  = 4'h5,
      st_skip     = 4'h4,
      st_copy     = 4'hc,
      st_done     = 4'hd,
      st_error    = 4'hf
   } load_state_e;

   typedef logic [7:0] half_period_t;

endpackage

// [core/spi_byte_engine.sv]
`timescale 1ns/1ps
`include "loader_consts.svh"

module spi_byte_engine (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic start,
   input wire loader_pkg::half_period_t half_period,
   input wire logic [7:0] tx_byte,
   input wire logic miso,
   output logic busy,
   output logic done,
   output logic [7:0] rx_byte,
   output logic sck,
   output logic mosi
);

   logic [7:0] div_cnt;
   logic [2:0] bit_cnt;
   logic [7:0] shift;
   logic half_end;

   assign half_end = (div_cnt == half_period - 8'h01);

   ////////////////////////////////////////////////////////////////
   // divider and bit sequencing, spi mode 0
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         busy <= 1'b0;
         done <= 1'b0;
         div_cnt <= 8'h00;
         bit_cnt <= 3'h0;
         sck <= 1'b0;
      end else begin
         done <= 1'b0;
         if (start && !busy) begin
            busy <= 1'b1;
            div_cnt <= 8'h00;
            bit_cnt <= 3'h0;
            sck <= 1'b0;
         end else if (busy) begin
            if (half_end) begin
               div_cnt <= 8'h00;
               sck <= !sck;
               if (sck) begin
                  bit_cnt <= bit_cnt + 3'h1;
                  if (bit_cnt == 3'h7) begin
                     busy <= 1'b0;
                     done <= 1'b1;
                  end
               end
            end else begin
               div_cnt <= div_cnt + 8'h01;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////
   // data: out msb first, sampled as sck falls; the synchronised
   // miso lags four cycles, so the half period is never below three
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         shift <= 8'h00;
         mosi <= 1'b0;
         rx_byte <= 8'h00;
      end else if (start && !busy) begin
         shift <= tx_byte;
         mosi <= tx_byte[7];
      end else if (busy && half_end && sck) begin
         shift <= {shift[6:0], miso};
         mosi <= shift[6];
         if (bit_cnt == 3'h7) begin
            rx_byte <= {shift[6:0], miso};
         end
      end
   end

endmodule

// [core/eeprom_boot_image_loader.sv]
`timescale 1ns/1ps
`include "loader_consts.svh"

// Function
// R1: low header nibble sets spi rate first
// R2: bit 3: eeprom limit 0.5 or 1 MHz
// R3: bits 2..0: crystal 4 to 20 MHz
// R4: byte 1 is program offset N
// R5: byte 2 is length in 256-byte blocks
// R6: block count includes the header block
// R7: bytes before N are skipped uninterpreted
// R8: byte N to ram 0, then ascending
// R9: load starts by itself after reset
// R10: writes stay inside 4k program ram
// R11: sequential read from zero, stop after last block
// R12: cpu runs only after last byte written
module eeprom_boot_image_loader (
   input wire logic clk,
   input wire logic reset_n,
   output logic spi_sck,
   output logic spi_cs_n,
   output logic spi_mosi,
   input wire logic spi_miso,
   output logic ram_we,
   output logic [11:0] ram_addr,
   output logic [7:0] ram_wdata,
   output logic cpu_run,
   output logic load_busy,
   output logic load_error,
   output logic image_truncated
);

   loader_pkg::load_state_e state;
   loader_pkg::half_period_t half_period;
   logic [2:0] miso_sync;
   logic miso_filt;
   logic inflight;
   logic xfer_start;
   logic xfer_busy;
   logic xfer_done;
   logic [7:0] rx_byte;
   logic [7:0] tx_byte;
   logic [15:0] image_index;
   logic [7:0] prog_offset;
   logic [7:0] block_count;
   logic [15:0] last_index;
   logic [15:0] dest_index;
   logic at_offset_next;

   // spi half period in clk cycles, rounded up so the eeprom limit holds
   function automatic loader_pkg::half_period_t half_cycles(input logic [2:0] code, input logic fast);
      int unsigned xtal_khz;
      int unsigned spi_khz;
      int unsigned half;
      xtal_khz = (code > `LDR_XO_MAX_CODE) ? 32'(`LDR_XO_MAX_CODE + 3'h1) * `LDR_XTAL_STEP_KHZ
                                           : 32'(code + 3'h1) * `LDR_XTAL_STEP_KHZ;
      spi_khz = fast ? `LDR_SPI_FAST_KHZ : `LDR_SPI_SLOW_KHZ;
      half = (xtal_khz + 2 * spi_khz - 1) / (2 * spi_khz);
      // slower than asked at 4 MHz with a fast eeprom, never faster
      if (half < 32'(`LDR_MIN_HALF)) begin
         half = 32'(`LDR_MIN_HALF);
      end
      return half[7:0];
   endfunction

   ////////////////////////////////////////////////////////////////
   // miso synchroniser: first stage feeds only the second
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         miso_sync <= 3'h0;
         miso_filt <= 1'b0;
      end else begin
         miso_sync <= {miso_sync[1:0], spi_miso};
         if (miso_sync[1] == miso_sync[2]) begin
            miso_filt <= miso_sync[2];
         end
      end
   end

   ////////////////////////////////////////////////////////////////
   // byte transfers
   // no new byte once the sequence has ended, so sck stays still with select high
   assign xfer_start = !inflight && state != loader_pkg::st_idle && state != loader_pkg::st_done
                       && state != loader_pkg::st_error;
   // block count includes block zero, so the last byte sits in block count - 1
   assign last_index = {block_count - 8'h01, `LDR_BLOCK_LAST}; // R6
   assign dest_index = image_index - {8'h00, prog_offset};
   assign at_offset_next = (image_index + 16'h0001) == {8'h00, prog_offset};

   always_comb begin
      case (state)
         loader_pkg::st_cmd: tx_byte = `LDR_CMD_READ; // R11
         loader_pkg::st_addr_hi: tx_byte = 8'(`LDR_IMAGE_START >> 8);
         loader_pkg::st_addr_lo: tx_byte = 8'(`LDR_IMAGE_START & 16'h00ff);
         default: tx_byte = 8'h00;
      endcase
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         inflight <= 1'b0;
      end else if (xfer_done) begin
         inflight <= 1'b0;
      end else if (xfer_start) begin
         inflight <= 1'b1;
      end
   end

   spi_byte_engine engine (
      .clk(clk),
      .reset_n(reset_n),
      .start(xfer_start),
      .half_period(half_period),
      .tx_byte(tx_byte),
      .miso(miso_filt),
      .busy(xfer_busy),
      .done(xfer_done),
      .rx_byte(rx_byte),
      .sck(spi_sck),
      .mosi(spi_mosi)
   );

   ////////////////////////////////////////////////////////////////
   // spi rate: slowest safe rate until header byte zero arrives
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         half_period <= `LDR_SAFE_HALF;
      end else if (xfer_done && state == loader_pkg::st_hdr_rate) begin
         half_period <= half_cycles(rx_byte[`LDR_XO_MSB:`LDR_XO_LSB], rx_byte[`LDR_SPEED_BIT]); // R1 R2 R3
      end
   end

   ////////////////////////////////////////////////////////////////
   // load sequence
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state <= loader_pkg::st_idle;
         image_index <= 16'h0000;
         prog_offset <= 8'h00;
         block_count <= 8'h00;
         load_error <= 1'b0;
         image_truncated <= 1'b0;
      end else begin
         case (state)
            loader_pkg::st_idle: begin
               state <= loader_pkg::st_cmd; // R9
            end
            loader_pkg::st_cmd: begin
               if (xfer_done) begin
                  state <= loader_pkg::st_addr_hi;
               end
            end
            loader_pkg::st_addr_hi: begin
               if (xfer_done) begin
                  state <= loader_pkg::st_addr_lo;
               end
            end
            loader_pkg::st_addr_lo: begin
               if (xfer_done) begin
                  image_index <= 16'h0000; // R11
                  state <= loader_pkg::st_hdr_rate;
               end
            end
            loader_pkg::st_hdr_rate: begin
               if (xfer_done) begin
                  image_index <= image_index + 16'h0001;
                  state <= loader_pkg::st_hdr_offs;
               end
            end
            loader_pkg::st_hdr_offs: begin
               if (xfer_done) begin
                  prog_offset <= rx_byte; // R4
                  image_index <= image_index + 16'h0001;
                  state <= loader_pkg::st_hdr_len;
               end
            end
            loader_pkg::st_hdr_len: begin
               if (xfer_done) begin
                  block_count <= rx_byte; // R5 R6
                  image_index <= image_index + 16'h0001;
                  // offset must clear the header and fall inside the counted blocks
                  if (prog_offset < `LDR_MIN_PROG_OFFSET || rx_byte == 8'h00) begin
                     load_error <= 1'b1;
                     state <= loader_pkg::st_error;
                  end else if (image_index == {8'h00, prog_offset} - 16'h0001) begin
                     state <= loader_pkg::st_copy;
                  end else begin
                     state <= loader_pkg::st_skip;
                  end
               end
            end
            loader_pkg::st_skip: begin
               if (xfer_done) begin
                  image_index <= image_index + 16'h0001; // R7
                  if (at_offset_next) begin
                     state <= loader_pkg::st_copy;
                  end
               end
            end
            loader_pkg::st_copy: begin
               if (xfer_done) begin
                  image_index <= image_index + 16'h0001;
                  if (image_index == last_index) begin
                     state <= loader_pkg::st_done; // R11
                  end else if (dest_index[11:0] == `LDR_RAM_LAST || dest_index[15:12] != 4'h0) begin
                     image_truncated <= 1'b1; // R10
                     state <= loader_pkg::st_done;
                  end
               end
            end
            loader_pkg::st_done: begin
               state <= loader_pkg::st_done;
            end
            loader_pkg::st_error: begin
               state <= loader_pkg::st_error;
            end
            default: begin
               state <= loader_pkg::st_error;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////
   // program ram write port
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ram_we <= 1'b0;
         ram_addr <= 12'h000;
         ram_wdata <= 8'h00;
      end else begin
         ram_we <= 1'b0;
         if (xfer_done && state == loader_pkg::st_copy && dest_index[15:12] == 4'h0) begin
            ram_we <= 1'b1; // R10
            ram_addr <= dest_index[11:0]; // R8
            ram_wdata <= rx_byte;
         end
      end
   end

   ////////////////////////////////////////////////////////////////
   // chip select, busy and cpu release
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         spi_cs_n <= 1'b1;
         load_busy <= 1'b0;
         cpu_run <= 1'b0;
      end else begin
         // select stays low across the whole read, one sequential stream
         spi_cs_n <= !(state != loader_pkg::st_idle && state != loader_pkg::st_done
                       && state != loader_pkg::st_error);
         load_busy <= (state != loader_pkg::st_done && state != loader_pkg::st_error
                       && state != loader_pkg::st_idle) || (state == loader_pkg::st_idle);
         // released two cycles after the final ram write strobe, with one clear cycle between
         cpu_run <= (state == loader_pkg::st_done) && !ram_we && !xfer_busy; // R12
      end
   end

endmodule

// [tb/loader_asserts.sv]
`timescale 1ns/1ps
module loader_asserts (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic spi_sck,
   input wire logic spi_cs_n,
   input wire logic spi_mosi,
   input wire logic spi_miso,
   input wire logic ram_we,
   input wire logic [11:0] ram_addr,
   input wire logic [7:0] ram_wdata,
   input wire logic cpu_run,
   input wire logic load_busy,
   input wire logic load_error,
   input wire logic image_truncated
);
   ////////////////////////////////////////////////////////////////
   // write tracker, cleared by reset so a reload restarts at zero
   logic seen;
   logic [11:0] last;
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         seen <= 1'b0;
         last <= 12'h000;
      end else if (ram_we) begin
         seen <= 1'b1;
         last <= ram_addr;
      end
   end
   ////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!reset_n);
   sequence s_wr;
      ram_we ##1 !ram_we;
   endsequence
   sequence s_launch;
      !ram_we ##1 $rose(cpu_run);
   endsequence
   AST_WE_PULSE: assert property (ram_we |-> s_wr)
      else $error("ram strobe longer than one cycle");
   AST_FIRST_ZERO: assert property (ram_we && !seen |-> ram_addr == 12'h000)
      else $error("first program byte not at zero");
   AST_ADDR_STEP: assert property (ram_we && seen |-> ram_addr == last + 12'h001)
      else $error("ram address not ascending by one");
   AST_RUN_LATE: assert property (s_launch |-> !load_busy && spi_cs_n)
      else $error("cpu released while loading");
   AST_RUN_STICKY: assert property (cpu_run |=> cpu_run)
      else $error("cpu run dropped");
   AST_NO_WR_RUN: assert property (cpu_run || load_error |-> !ram_we)
      else $error("ram written after load end");
   AST_ERR_STOP: assert property (load_error |=> !cpu_run && spi_cs_n)
      else $error("bad header still runs");
   AST_MOSI_STABLE: assert property (spi_sck && $past(spi_sck) |-> $stable(spi_mosi))
      else $error("mosi moved while sck high");
   AST_CS_BUSY: assert property (!spi_cs_n |-> load_busy)
      else $error("eeprom selected while idle");
   AST_SCK_IDLE: assert property (spi_cs_n |-> !spi_sck)
      else $error("sck pulsed without select");
endmodule

bind eeprom_boot_image_loader loader_asserts chk (.clk(clk), .reset_n(reset_n), .spi_sck(spi_sck),
   .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .spi_miso(spi_miso), .ram_we(ram_we), .ram_addr(ram_addr),
   .ram_wdata(ram_wdata), .cpu_run(cpu_run), .load_busy(load_busy), .load_error(load_error),
   .image_truncated(image_truncated));

// [tb/eeprom_model.sv]
`timescale 1ns/1ps
module eeprom_model (
   input wire logic spi_sck,
   input wire logic spi_cs_n,
   input wire logic spi_mosi,
   output logic spi_miso
);
   logic [7:0] img [0:1023];
   logic [23:0] hdr;
   logic [15:0] base;
   logic ok;
   int cnt;
   initial spi_miso = 1'b0;
   always @(negedge spi_cs_n) begin
      cnt = 0;
      ok = 1'b0;
   end
   // released line: no stale level for the loader to mistake for data
   always @(posedge spi_cs_n) spi_miso = ~spi_miso;
   always @(posedge spi_sck) begin
      if (!spi_cs_n) begin
         hdr = {hdr[22:0], spi_mosi};
         cnt = cnt + 1;
         if (cnt == 24) begin
            ok = (hdr[23:16] == 8'h03);
            base = hdr[15:0];
         end
      end
   end
   // only a read command gets data, anything else sees noise
   always @(negedge spi_sck) begin
      if (!spi_cs_n && cnt >= 24) begin
         if (ok)
            spi_miso = img[(base + (cnt - 24) / 8) % 1024][7 - (cnt - 24) % 8];
         else
            spi_miso = ~spi_miso;
      end
   end
endmodule

// [tb/testbench.sv]
`timescale 1ns/1ps
module testbench;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic spi_sck, spi_cs_n, spi_mosi, spi_miso, ram_we, cpu_run, load_busy, load_error, image_truncated;
   logic [11:0] ram_addr;
   logic [7:0] ram_wdata;
   int n_fail = 0;
   int num_checks = 0;
   always #10 clk = ~clk;
   eeprom_boot_image_loader dut (.clk(clk), .reset_n(reset_n), .spi_sck(spi_sck), .spi_cs_n(spi_cs_n),
      .spi_mosi(spi_mosi), .spi_miso(spi_miso), .ram_we(ram_we), .ram_addr(ram_addr), .ram_wdata(ram_wdata),
      .cpu_run(cpu_run), .load_busy(load_busy), .load_error(load_error), .image_truncated(image_truncated));
   eeprom_model em (.spi_sck(spi_sck), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .spi_miso(spi_miso));
   ////////////////////////////////////////////////////////////////
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // a fresh reset each time, so the later calls from t_rates and the call from t_load also exercise a mid-run reset
   task automatic fill(input logic [7:0] b0, input logic [7:0] b1, input logic [7:0] b2);
      for (int i = 0; i < 1024; i++) em.img[i] = 8'(i * 7 + 1);
      em.img[0] = b0;
      em.img[1] = b1;
      em.img[2] = b2;
      @(negedge clk);
      reset_n = 1'b0;
      repeat (3) @(negedge clk);
      reset_n = 1'b1;
   endtask
   task automatic wait_rises(input int n);
      int seen;
      logic prev;
      seen = 0;
      prev = spi_sck;
      for (int t = 0; t < 20000 && seen < n; t++) begin
         @(posedge clk);
         #1;
         if (spi_sck && !prev) seen++;
         prev = spi_sck;
      end
      if (seen < n) begin
         n_fail++;
         close_out();
      end
   endtask
   ////////////////////////////////////////////////////////////////
   task automatic t_rates();
      int h, x, s, e;
      for (int c = 0; c < 16; c++) begin
         fill(8'(c), 8'h05, 8'h01);
         wait_rises(57);
         h = 0;
         while (spi_sck && h < 100) begin
            @(posedge clk);
            #1;
            h++;
         end
         x = (c % 8 > 4) ? 20000 : 4000 * (c % 8 + 1);
         s = c[3] ? 1000 : 500;
         e = (x + 2 * s - 1) / (2 * s);
         // floor of three: the loader may run slower than the eeprom allows, never faster
         if (e < 3) e = 3;
         check(16'(h), 16'(e));
      end
      $display("rate table done");
   endtask
   task automatic t_load();
      int k;
      k = 0;
      fill(8'h08, 8'h05, 8'h01);
      for (int t = 0; t < 20000 && !cpu_run; t++) begin
         @(posedge clk);
         #1;
         if (ram_we) begin
            check(16'(ram_addr), 16'(k));
            check(16'(ram_wdata), 16'(em.img[5 + k]));
            k++;
         end
      end
      check(16'(k), 16'h00fb);
      check(16'(cpu_run), 16'h0001);
      check(16'(load_busy), 16'h0000);
      check(16'(spi_cs_n), 16'h0001);
      check(16'(image_truncated), 16'h0000);
      check(16'(load_error), 16'h0000);
      $display("image load done");
   endtask
   task automatic t_errors();
      int w;
      for (int i = 0; i < 2; i++) begin
         fill(8'h08, i ? 8'h02 : 8'h05, i ? 8'h01 : 8'h00);
         w = 0;
         for (int t = 0; t < 5000 && !load_error; t++) begin
            @(posedge clk);
            #1;
            if (ram_we) w++;
         end
         check(16'(load_error), 16'h0001);
         check(16'(w), 16'h0000);
         check(16'(cpu_run), 16'h0000);
      end
      $display("bad header done");
   endtask
   initial begin
      t_rates();
      t_load();
      t_errors();
      close_out();
   end
endmodule
